/* rtl/isc_defs.vh */
// constants for the image sequencer configuration bank
// assumes inclusion by bare name from rtl/isc_config_regs.v
`ifndef ISC_DEFS_VH
`define ISC_DEFS_VH

`define ISC_ADR_CTRL 4'h0
`define ISC_ADR_COL 4'h1
`define ISC_ADR_ROW 4'h2
`define ISC_ADR_KCNT 4'h3
`define ISC_ADR_RES1 4'h4
`define ISC_ADR_RES2 4'h5
`define ISC_ADR_RES3 4'h6
`define ISC_ADR_FT 4'h7
`define ISC_ADR_VCAL 4'h8
`define ISC_ADR_VBLK 4'h9
`define ISC_ADR_VOFS 4'hA
`define ISC_ADR_AIN 4'hB
`define ISC_ADR_PGA 4'hC
`define ISC_ADR_TRL 4'hD
`define ISC_ADR_TRM 4'hE
`define ISC_ADR_TRH 4'hF

`define ISC_RST_CTRL 12'h029
`define ISC_RST_COL 12'h000
`define ISC_RST_ROW 12'h000
`define ISC_RST_KCNT 12'h0A0
`define ISC_RST_RES1 12'h002
`define ISC_RST_RES2 12'h000
`define ISC_RST_RES3 12'h000
`define ISC_RST_FT 12'h1E1
`define ISC_RST_VCAL 12'h04A
`define ISC_RST_VBLK 12'h06B
`define ISC_RST_VOFS 12'h055
`define ISC_RST_AIN 12'h0F0
`define ISC_RST_PGA 12'hFB0
`define ISC_RST_TRL 12'hADF
`define ISC_RST_TRM 12'h6DB
`define ISC_RST_TRH 12'h0DB

`define ISC_MSK_8 12'h0FF
`define ISC_MSK_9 12'h1FF
`define ISC_MSK_11 12'h7FF
`define ISC_MSK_12 12'hFFF

// timing_control field positions
`define ISC_B_MASTER 0
`define ISC_B_SKIP 1
`define ISC_B_GRAN_LO 2
`define ISC_B_GRAN_HI 3
`define ISC_B_AOUT 4
`define ISC_B_CALLINE 5
`define ISC_B_DUAL 6
`define ISC_B_TRIPLE 7
`define ISC_B_REVX 8
`define ISC_B_REVY 9
`define ISC_B_NDR 10

// serial word layout
`define ISC_W_ADR_HI 15
`define ISC_W_ADR_LO 12
`define ISC_W_DAT_HI 11
`define ISC_W_DAT_LO 0

`define ISC_DIV_LAST 2'h3
`define ISC_ROT_TICKS 8'h0A
`define ISC_FOT_TICKS 8'h20
`define ISC_LAST_ROW 9'h1DF
`define ISC_STEP_ONE 12'h001
`define ISC_STEP_TWO 12'h002

`endif

/* rtl/isc_config_regs.v */
// configuration bank and readout sequencer of the image sensor
// assumes serial port and sequencer reset pins arrive unsynchronised
// and i_clk is the sensor input clock
//
// Summary of operation
// [RULE_01] sequencer advances once every four input clocks
// [RULE_02] master bit: 1 sequencer times all, 0 three pins time integration
// [RULE_03] row-skip reads one row, skips one, vertical only, default off
// [RULE_04] two-bit granularity code chosen by clock rate, default 10
// [RULE_05] controller writes registers only while frame valid is low
// [RULE_06] master and granularity change only while sequencer reset held
// [RULE_07] analog output enable bit, 1 on, reset 0
// [RULE_08] calibration per line when 1 (default), per frame when 0
// [RULE_09] dual slope on: extra reset at its position, else ignored
// [RULE_10] triple slope on: second extra reset at its position
// [RULE_11] horizontal reverse reads columns right to left
// [RULE_12] vertical reverse reads rows bottom to top
// [RULE_13] non-destructive readout bit, reset 0
// [RULE_14] first column is eight times column start, range 0 to 79
// [RULE_15] row start picks any line 0 to 479 as first row
// [RULE_16] kernel count 1 to 160, four pixels each per line
// [RULE_17] pixel reset high for value minus one line times, default 2
// [RULE_18] dual reset pulse after value minus one lines
// [RULE_19] triple reset pulse after value minus one lines
// [RULE_20] frame transfer after value minus one lines, ends integration
// [RULE_21] dac codes map inversely, 00 is 2.5V, FF is 0V
// [RULE_22] 16-bit word, top four bits address, low twelve data, load on enable
// [RULE_23] line counter starts 1, or 2 stepping two when skipping rows
// [RULE_24] control fields packed from bit 0 in the listed order

`timescale 1ns/1ps
`include "isc_defs.vh"

module isc_config_regs (
   input wire i_clk,
   input wire i_reset,
   input wire i_seq_reset_n,
   input wire i_spi_clk,
   input wire i_spi_data,
   input wire i_spi_enable,
   input wire [2:0] i_int_time,
   output wire [2:0] o_int_time,
   output wire [2:0] o_int_time_oe,
   output reg o_core_clk,
   output reg o_frame_valid,
   output reg o_line_valid,
   output reg [8:0] o_row_addr,
   output reg [9:0] o_col_addr,
   output reg o_pixel_reset,
   output reg o_dual_reset,
   output reg o_triple_reset,
   output reg o_transfer,
   output wire o_master,
   output wire [1:0] o_gran,
   output wire o_analog_out_en,
   output wire o_calib_every_line,
   output wire o_nondestructive,
   output wire [7:0] o_cal_dac,
   output wire [7:0] o_black_dac,
   output wire [7:0] o_shift_dac,
   output wire [11:0] o_adc_input_sel,
   output wire [11:0] o_amp_settings,
   output wire [32:0] o_adc_trim
);

   localparam S_FOT = 3'b001;
   localparam S_ROT = 3'b010;
   localparam S_READ = 3'b100;

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers

   reg [2:0] sclk_q;
   reg [1:0] sdat_q;
   reg [2:0] sen_q;
   reg [1:0] srst_q;
   reg [2:0] int1_q;
   reg [1:0] int2_q;
   reg [1:0] int3_q;

   always @(posedge i_clk) begin
      if (i_reset) begin
         sclk_q <= 3'h0;
         sdat_q <= 2'h0;
         sen_q <= 3'h0;
         srst_q <= 2'h0;
         int1_q <= 3'h0;
         int2_q <= 2'h0;
         int3_q <= 2'h0;
      end else begin
         sclk_q <= {sclk_q[1:0], i_spi_clk};
         sdat_q <= {sdat_q[0], i_spi_data};
         sen_q <= {sen_q[1:0], i_spi_enable};
         srst_q <= {srst_q[0], i_seq_reset_n};
         int1_q <= {int1_q[1:0], i_int_time[0]};
         int2_q <= {int2_q[0], i_int_time[1]};
         int3_q <= {int3_q[0], i_int_time[2]};
      end
   end

   // edges use stages two and three only
   wire sclk_rise = sclk_q[1] & ~sclk_q[2];
   wire sen_rise = sen_q[1] & ~sen_q[2];
   wire seq_run = srst_q[1];
   wire int1_fall = ~int1_q[1] & int1_q[2];

   ////////////////////////////////////////////////////////////////////
   // serial word capture
   // oversampled at the system clock, so the serial clock must stay
   // well below half of i_clk for edges to be seen

   reg [15:0] shift_q;
   reg load_q;

   always @(posedge i_clk) begin
      if (i_reset) begin
         shift_q <= 16'h0000;
         load_q <= 1'b0;
      end else begin
         if (sclk_rise)
            shift_q <= {shift_q[14:0], sdat_q[1]};
         load_q <= sen_rise; // RULE_22
      end
   end

   wire [3:0] wr_adr = shift_q[`ISC_W_ADR_HI:`ISC_W_ADR_LO];
   wire [11:0] wr_dat = shift_q[`ISC_W_DAT_HI:`ISC_W_DAT_LO];

   ////////////////////////////////////////////////////////////////////
   // register array

   function [11:0] isc_rst;
      input [3:0] a;
      begin
         case (a)
            `ISC_ADR_CTRL: isc_rst = `ISC_RST_CTRL;
            `ISC_ADR_COL: isc_rst = `ISC_RST_COL;
            `ISC_ADR_ROW: isc_rst = `ISC_RST_ROW;
            `ISC_ADR_KCNT: isc_rst = `ISC_RST_KCNT;
            `ISC_ADR_RES1: isc_rst = `ISC_RST_RES1;
            `ISC_ADR_RES2: isc_rst = `ISC_RST_RES2;
            `ISC_ADR_RES3: isc_rst = `ISC_RST_RES3;
            `ISC_ADR_FT: isc_rst = `ISC_RST_FT;
            `ISC_ADR_VCAL: isc_rst = `ISC_RST_VCAL;
            `ISC_ADR_VBLK: isc_rst = `ISC_RST_VBLK;
            `ISC_ADR_VOFS: isc_rst = `ISC_RST_VOFS;
            `ISC_ADR_AIN: isc_rst = `ISC_RST_AIN;
            `ISC_ADR_PGA: isc_rst = `ISC_RST_PGA;
            `ISC_ADR_TRL: isc_rst = `ISC_RST_TRL;
            `ISC_ADR_TRM: isc_rst = `ISC_RST_TRM;
            default: isc_rst = `ISC_RST_TRH;
         endcase
      end
   endfunction

   function [11:0] isc_msk;
      input [3:0] a;
      begin
         case (a)
            `ISC_ADR_CTRL: isc_msk = `ISC_MSK_11;
            `ISC_ADR_ROW: isc_msk = `ISC_MSK_9;
            `ISC_ADR_TRH: isc_msk = `ISC_MSK_9;
            `ISC_ADR_COL: isc_msk = `ISC_MSK_8;
            `ISC_ADR_KCNT: isc_msk = `ISC_MSK_8;
            `ISC_ADR_VCAL: isc_msk = `ISC_MSK_8;
            `ISC_ADR_VBLK: isc_msk = `ISC_MSK_8;
            `ISC_ADR_VOFS: isc_msk = `ISC_MSK_8;
            default: isc_msk = `ISC_MSK_12;
         endcase
      end
   endfunction

   reg [11:0] regs_q [0:15];

   genvar gi;
   generate
      for (gi = 0; gi < 16; gi = gi + 1) begin : g_reg
         // a genvar cannot be part-selected, so size the address here
         localparam [3:0] ADR = gi;
         always @(posedge i_clk) begin
            if (i_reset)
               regs_q[gi] <= isc_rst(ADR);
            else if (load_q && wr_adr == ADR)
               regs_q[gi] <= wr_dat & isc_msk(ADR); // RULE_22
         end
      end
   endgenerate

   wire [11:0] ctrl = regs_q[`ISC_ADR_CTRL];
   wire [7:0] col_start = regs_q[`ISC_ADR_COL][7:0];
   wire [8:0] row_start = regs_q[`ISC_ADR_ROW][8:0];
   wire [7:0] kcount = regs_q[`ISC_ADR_KCNT][7:0];
   wire [11:0] res1_len = regs_q[`ISC_ADR_RES1];
   wire [11:0] res2_pos = regs_q[`ISC_ADR_RES2];
   wire [11:0] res3_pos = regs_q[`ISC_ADR_RES3];
   wire [11:0] ft_pos = regs_q[`ISC_ADR_FT];

   // RULE_24
   wire master = ctrl[`ISC_B_MASTER];
   wire row_skip = ctrl[`ISC_B_SKIP];
   wire dual_slope_on = ctrl[`ISC_B_DUAL];
   wire triple_slope_on = ctrl[`ISC_B_TRIPLE];
   wire rev_x = ctrl[`ISC_B_REVX];
   wire rev_y = ctrl[`ISC_B_REVY];

   assign o_master = master; // RULE_02
   assign o_gran = ctrl[`ISC_B_GRAN_HI:`ISC_B_GRAN_LO]; // RULE_04
   assign o_analog_out_en = ctrl[`ISC_B_AOUT]; // RULE_07
   assign o_calib_every_line = ctrl[`ISC_B_CALLINE]; // RULE_08
   assign o_nondestructive = ctrl[`ISC_B_NDR]; // RULE_13
   // codes pass straight to the dacs, whose output falls as code rises
   assign o_cal_dac = regs_q[`ISC_ADR_VCAL][7:0]; // RULE_21
   assign o_black_dac = regs_q[`ISC_ADR_VBLK][7:0]; // RULE_21
   assign o_shift_dac = regs_q[`ISC_ADR_VOFS][7:0];
   assign o_adc_input_sel = regs_q[`ISC_ADR_AIN];
   assign o_amp_settings = regs_q[`ISC_ADR_PGA];
   assign o_adc_trim = {regs_q[`ISC_ADR_TRH][8:0],
                        regs_q[`ISC_ADR_TRM],
                        regs_q[`ISC_ADR_TRL]};

   ////////////////////////////////////////////////////////////////////
   // core clock divider

   reg [1:0] div_q;

   always @(posedge i_clk) begin
      if (i_reset)
         div_q <= 2'h0;
      else
         div_q <= div_q + 2'h1; // RULE_01
   end

   wire tick = (div_q == `ISC_DIV_LAST); // RULE_01

   always @(posedge i_clk) begin
      if (i_reset)
         o_core_clk <= 1'b0;
      else
         o_core_clk <= div_q[1];
   end

   ////////////////////////////////////////////////////////////////////
   // readout sequencer

   reg [2:0] state_q;
   reg [7:0] cnt_q;
   reg [11:0] line_q;
   reg [8:0] ridx_q;
   reg [7:0] kidx_q;
   reg slave_ft_q;

   wire [11:0] step = row_skip ? `ISC_STEP_TWO : `ISC_STEP_ONE; // RULE_03
   wire [11:0] line_nx = line_q + step;
   wire last_k = ({1'b0, kidx_q} + 9'h001 >= {1'b0, kcount}); // RULE_16
   // master compares line count, slave waits for the integration pin
   wire ft_hit = master ? (line_nx >= ft_pos) : slave_ft_q; // RULE_20

   always @(posedge i_clk) begin
      if (i_reset || !seq_run) begin
         state_q <= S_FOT;
         cnt_q <= 8'h00;
         line_q <= `ISC_STEP_ONE;
         ridx_q <= 9'h000;
         kidx_q <= 8'h00;
         slave_ft_q <= 1'b0;
      end else begin
         if (int1_fall)
            slave_ft_q <= 1'b1;
         if (tick) begin
            case (state_q)
               S_FOT: begin
                  if (cnt_q + 8'h01 >= `ISC_FOT_TICKS) begin
                     state_q <= S_ROT;
                     cnt_q <= 8'h00;
                     line_q <= step; // RULE_23
                     ridx_q <= 9'h000;
                     slave_ft_q <= int1_fall;
                  end else
                     cnt_q <= cnt_q + 8'h01;
               end
               S_ROT: begin
                  if (cnt_q + 8'h01 >= `ISC_ROT_TICKS) begin
                     state_q <= S_READ;
                     cnt_q <= 8'h00;
                     kidx_q <= 8'h00;
                  end else
                     cnt_q <= cnt_q + 8'h01;
               end
               S_READ: begin
                  if (last_k) begin
                     line_q <= line_nx; // RULE_23
                     ridx_q <= ridx_q + step[8:0]; // RULE_03
                     state_q <= ft_hit ? S_FOT : S_ROT;
                  end else
                     kidx_q <= kidx_q + 8'h01;
               end
               default: begin
                  state_q <= S_FOT;
                  cnt_q <= 8'h00;
               end
            endcase
         end
      end
   end

   wire in_fot = (state_q == S_FOT);
   wire line_start = tick && state_q == S_ROT && cnt_q == 8'h00;

   // addresses; callers keep start plus window inside the array
   wire [8:0] row_fwd = row_start + ridx_q; // RULE_15
   wire [8:0] row_rev = `ISC_LAST_ROW - row_fwd; // RULE_12
   wire [9:0] col_base = {col_start[6:0], 3'h0}; // RULE_14
   wire [7:0] kpos = rev_x ? (kcount - 8'h01 - kidx_q) : kidx_q; // RULE_11

   ////////////////////////////////////////////////////////////////////
   // integration timing and outputs

   wire m_pix_rst = ~in_fot && line_q < res1_len; // RULE_17
   wire m_int2 = dual_slope_on && ~in_fot && line_q >= res2_pos; // RULE_09
   wire m_int3 = triple_slope_on && ~in_fot && line_q >= res3_pos; // RULE_10

   assign o_int_time = {m_int3, m_int2, ~in_fot & ~m_pix_rst};
   assign o_int_time_oe = {3{master}}; // RULE_02

   always @(posedge i_clk) begin
      if (i_reset) begin
         o_frame_valid <= 1'b0;
         o_line_valid <= 1'b0;
         o_row_addr <= 9'h000;
         o_col_addr <= 10'h000;
         o_pixel_reset <= 1'b1;
         o_dual_reset <= 1'b0;
         o_triple_reset <= 1'b0;
         o_transfer <= 1'b0;
      end else begin
         o_frame_valid <= seq_run && ~in_fot;
         o_line_valid <= seq_run && state_q == S_READ;
         o_row_addr <= rev_y ? row_rev : row_fwd; // RULE_12
         o_col_addr <= col_base + {kpos[7:0], 2'h0}; // RULE_16
         if (master) begin
            o_pixel_reset <= m_pix_rst; // RULE_17
            o_dual_reset <= line_start && dual_slope_on
                            && line_q == res2_pos; // RULE_18
            o_triple_reset <= line_start && triple_slope_on
                              && line_q == res3_pos; // RULE_19
         end else begin
            o_pixel_reset <= ~int1_q[1]; // RULE_02
            o_dual_reset <= dual_slope_on & ~int2_q[1];
            o_triple_reset <= triple_slope_on & ~int3_q[1];
         end
         o_transfer <= tick && state_q == S_READ && last_k && ft_hit; // RULE_20
      end
   end

endmodule

/* testbench/isc_config_regs_asserts.sv */
// port assertions for the configuration bank and sequencer
// assumes binding into isc_config_regs, single clock domain
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module isc_config_regs_asserts (
   input wire i_clk,
   input wire i_reset,
   input wire i_seq_reset_n,
   input wire i_spi_enable,
   input wire [2:0] o_int_time_oe,
   input wire o_core_clk,
   input wire o_frame_valid,
   input wire o_line_valid,
   input wire [8:0] o_row_addr,
   input wire [9:0] o_col_addr,
   input wire o_pixel_reset,
   input wire o_transfer,
   input wire o_master,
   input wire [1:0] o_gran,
   input wire o_analog_out_en,
   input wire o_calib_every_line,
   input wire o_nondestructive,
   input wire [7:0] o_cal_dac
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   core_div_a: assert property ($rose(o_core_clk) |=> ##3 $rose(o_core_clk))
      else $error("core clock period not four");
   pin_dir_a: assert property (o_int_time_oe == {3{o_master}})
      else $error("pin enables disagree with master bit");
   reset_dflt_a: assert property ($fell(i_reset) |-> o_master && o_gran == 2'b10 && !o_analog_out_en
      && o_calib_every_line && !o_nondestructive && o_pixel_reset)
      else $error("control defaults wrong after reset");
   seq_hold_a: assert property ((!i_seq_reset_n)[*4] |-> !o_frame_valid && !o_line_valid)
      else $error("sequencer runs while held");
   line_in_frame_a: assert property (o_line_valid |-> o_frame_valid)
      else $error("line valid outside frame");
   rot_first_a: assert property ($rose(o_line_valid) |-> $past(o_frame_valid, 32))
      else $error("row overhead too short");
   addr_range_a: assert property (o_line_valid |-> o_col_addr[1:0] == 2'b00 && o_row_addr <= 9'h1DF)
      else $error("address out of range");
   xfer_pulse_a: assert property (o_transfer |=> !o_transfer)
      else $error("transfer longer than one cycle");
   xfer_fot_a: assert property (o_transfer |-> ##[0:40] !o_frame_valid)
      else $error("no frame overhead after transfer");
   load_delay_a: assert property ($changed(o_cal_dac) |-> $past(i_spi_enable, 3) || $past(i_spi_enable, 4) || $past(i_reset))
      else $error("register changed without a load");
   cover property ($rose(o_frame_valid));
   cover property ($rose(o_line_valid));
   cover property (o_transfer);
endmodule
bind isc_config_regs isc_config_regs_asserts i_chk (.*);

/* testbench/isc_ctrl_model.sv */
// camera controller model: serial port writer and sequencer reset
// assumes the bench calls its tasks; drives pins on the falling edge
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module isc_ctrl_model (
   input wire i_clk,
   input wire i_frame_valid,
   output reg o_spi_clk,
   output reg o_spi_data,
   output reg o_spi_enable,
   output reg o_seq_reset_n
);
   initial begin
      o_spi_clk = 1'b0;
      o_spi_data = 1'b1;
      o_spi_enable = 1'b0;
      o_seq_reset_n = 1'b0;
   end
   // master and granularity words only go out while this is low
   task set_run(input v);
      begin
         @(negedge i_clk);
         o_seq_reset_n = v;
      end
   endtask
   task send(input [15:0] w);
      integer i;
      begin
         @(negedge i_clk);
         while (i_frame_valid) @(negedge i_clk);
         for (i = 15; i >= 0; i--) begin
            o_spi_data = w[i];
            repeat (2) @(negedge i_clk);
            o_spi_clk = 1'b1;
            repeat (2) @(negedge i_clk);
            o_spi_clk = 1'b0;
         end
         o_spi_enable = 1'b1;
         repeat (3) @(negedge i_clk);
         o_spi_enable = 1'b0;
         // released line must not keep its last value
         o_spi_data = ~o_spi_data;
         repeat (4) @(negedge i_clk);
      end
   endtask
endmodule

/* testbench/testbench.sv */
// self-checking bench for the configuration bank and sequencer
// assumes the controller model drives the serial and reset pins
`timescale 1ns/1ps
`include "isc_defs.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
   $display("unexpected at %0t got %0h exp %0h", $time, g, e); end end
////////////////////////////////////////////////////////////
module testbench;
   reg i_clk, i_reset;
   wire sck, sda, sen, srn, cclk, fv, lv, prst, drst, trst, xfer, mst, aout, cline, ndr;
   wire [2:0] ito, ioe;
   wire [8:0] row;
   wire [9:0] col;
   wire [1:0] gran;
   wire [7:0] cdac, bdac, sdac;
   wire [11:0] ain, pga;
   wire [32:0] trim;
   integer n_fail = 0, comparisons = 0, n_dual = 0, n_tri = 0;
   isc_config_regs i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_seq_reset_n(srn),
      .i_spi_clk(sck), .i_spi_data(sda), .i_spi_enable(sen), .i_int_time(3'h0),
      .o_int_time(ito), .o_int_time_oe(ioe), .o_core_clk(cclk), .o_frame_valid(fv),
      .o_line_valid(lv), .o_row_addr(row), .o_col_addr(col), .o_pixel_reset(prst),
      .o_dual_reset(drst), .o_triple_reset(trst), .o_transfer(xfer), .o_master(mst),
      .o_gran(gran), .o_analog_out_en(aout), .o_calib_every_line(cline),
      .o_nondestructive(ndr), .o_cal_dac(cdac), .o_black_dac(bdac), .o_shift_dac(sdac),
      .o_adc_input_sel(ain), .o_amp_settings(pga), .o_adc_trim(trim));
   isc_ctrl_model i_ctrl (.i_clk(i_clk), .i_frame_valid(fv), .o_spi_clk(sck),
      .o_spi_data(sda), .o_spi_enable(sen), .o_seq_reset_n(srn));
   always @(posedge i_clk) begin
      n_dual <= n_dual + drst;
      n_tri <= n_tri + trst;
   end
   ////////////////////////////////////////////////////////////
   task end_of_test;
      begin
         $display("comparisons %0d n_fail %0d", comparisons, n_fail);
         if (n_fail == 0 && comparisons > 0) $display("SIMULATION PASSED");
         else $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   task wait_lv(input v);
      integer k;
      begin
         k = 0;
         while (lv !== v && k < 4000) begin
            @(negedge i_clk);
            k++;
         end
         `CHK(lv, v)
      end
   endtask
   task t_defaults;
      begin
         `CHK({mst, gran, aout, cline, ndr, prst, ioe}, {1'b1, 2'b10, 3'b010, 1'b1, 3'h7})
         `CHK({cdac, bdac, sdac}, 24'h4A6B55)
         `CHK({ain, pga, trim}, {12'h0F0, 12'hFB0, 9'h0DB, 12'h6DB, 12'hADF})
      end
   endtask
   task t_ctrl;
      integer b;
      reg [11:0] v;
      begin
         for (b = 0; b < 12; b++) begin
            v = (b == 11) ? 12'h00C : 12'h001 << b;
            i_ctrl.send({`ISC_ADR_CTRL, v});
            `CHK({ndr, cline, aout, gran, mst, ioe}, {v[10], v[5], v[4], v[3:2], v[0], {3{v[0]}}})
         end
      end
   endtask
   task t_regs;
      integer a;
      reg [11:0] m, g, d;
      begin
         for (a = 8; a < 16; a++) begin
            d = 12'hA5C ^ a[11:0];
            m = (a < 11) ? 12'h0FF : (a == 15) ? 12'h1FF : 12'hFFF;
            i_ctrl.send({a[3:0], d});
            case (a)
               8: g = {4'h0, cdac};
               9: g = {4'h0, bdac};
               10: g = {4'h0, sdac};
               11: g = ain;
               12: g = pga;
               13: g = trim[11:0];
               14: g = trim[23:12];
               default: g = {3'h0, trim[32:24]};
            endcase
            `CHK(g, d & m)
         end
      end
   endtask
   task t_rst;
      begin
         i_ctrl.send({`ISC_ADR_VCAL, 12'h011});
         i_reset = 1'b1;
         @(negedge i_clk);
         i_reset = 1'b0;
         `CHK({cdac, mst}, {8'h4A, 1'b1})
      end
   endtask
   // kernel_count 2, column_start 3, row_start 5, transfer at 4
   task t_frame(input [11:0] c, input [8:0] r0, input [9:0] c0, input [8:0] r1);
      integer k;
      integer d0;
      integer t0;
      begin
         i_ctrl.set_run(1'b0);
         i_ctrl.send({`ISC_ADR_CTRL, c});
         d0 = n_dual;
         t0 = n_tri;
         i_ctrl.set_run(1'b1);
         wait_lv(1'b1);
         `CHK({row, col}, {r0, c0})
         k = 0;
         while (lv === 1'b1 && k < 100) begin
            @(negedge i_clk);
            k++;
         end
         `CHK(k, 8)
         wait_lv(1'b1);
         `CHK({row, prst, ito}, {r1, 1'b0, 1'b0, c[6], 1'b1})
         k = 0;
         while (xfer !== 1'b1 && k < 3000) begin
            @(negedge i_clk);
            k++;
         end
         `CHK({xfer, n_tri > t0, n_dual > d0}, {1'b1, c[7:6]})
      end
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   // whole run is near 2800 cycles; allow about nine times that
   initial begin
      #1000000;
      n_fail++;
      end_of_test;
   end
   initial begin
      i_reset = 1'b1;
      repeat (4) @(negedge i_clk);
      i_reset = 1'b0;
      t_defaults;
      t_ctrl;
      t_regs;
      t_rst;
      i_ctrl.send({`ISC_ADR_KCNT, 12'h002});
      i_ctrl.send({`ISC_ADR_COL, 12'h003});
      i_ctrl.send({`ISC_ADR_ROW, 12'h005});
      i_ctrl.send({`ISC_ADR_RES2, 12'h002});
      i_ctrl.send({`ISC_ADR_RES3, 12'h003});
      i_ctrl.send({`ISC_ADR_FT, 12'h004});
      t_frame(12'h0E9, 9'h005, 10'h018, 9'h006);
      t_frame(12'h329, 9'h1DA, 10'h01C, 9'h1D9);
      end_of_test;
   end
endmodule
